// >>> rtl/fmp_memory.sv
/*
 Memory map and protection core of the fob: eighteen 8-byte blocks,
 per-block write-cycle counters and the irreversible protection codes.
 Assumes the command layer above delivers block commands and bytes
 synchronous to mclk, one byte per strobe, LSb-first already
 reassembled into bytes. Storage is modelled as registers.
*/
// Contract
// - Eighteen blocks of eight bytes each
// - Blocks 00h-0Fh are user EEPROM
// - Four consecutive user blocks form a page
// - Protocol_parameter_block: app data, family id, users
// - Protection_control_block: page protects then lock bytes
// - Each page byte controls only its page
// - Lock bytes protect app data, id, user1
// - Self lock protects only itself
// - Locking code makes control byte unchangeable
// - Each block keeps 16-bit write counter
// - Counter saturates at 65535, writes still allowed
// - Counter returned only by extended read
// - Bytes 0..7 ascending, counter low first
// - 00h unlocked, 0Ah irreversible EPROM emulation
// - Ah nibble write-protect; bits only set
// - AAh locks irreversibly; other codes unlocked
// - LSb first, least significant byte first
`timescale 1ns/1ps
module fmp_memory
    import fmp_pkg::*;
(
    input  wire logic                           mclk,
    input  wire logic                           rstn,
    input  wire logic                           cmd_valid,
    input  wire logic                           cmd_write,
    input  wire logic                           cmd_ext,
    input  wire logic [fmp_pkg::BLK_W-1:0]      cmd_blk,
    input  wire logic                           wr_byte_valid,
    input  wire logic [7:0]                     wr_byte,
    output logic                                busy,
    output logic                                rd_byte_valid,
    output logic      [7:0]                     rd_byte,
    output logic                                rd_last,
    output logic                                wr_done,
    output logic                                wr_accepted,
    output logic                                cmd_error
);
    import fmp_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [63:0] mem_q [NUM_BLOCKS];
    fmp_state_e  state_q;
    logic [BLK_W-1:0]      blk_q;
    logic                  ext_q;
    logic [BYTE_IDX_W-1:0] idx_q;
    logic [63:0]           wbuf_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        blk_ok     = (cmd_blk < BLK_W'(NUM_BLOCKS));
    wire [63:0] cur_blk    = mem_q[blk_q];
    wire [63:0] prot_word  = mem_q[PROT_BLK];
    wire [15:0] cur_cnt;
    wire [63:0] merged;
    wire        allowed;
    wire [3:0]  last_idx   = ext_q ? CNT_HI_IDX : LAST_DATA_IDX;
    // Bytes ascend, counter low byte after byte 7
    wire [7:0]  out_byte   = (idx_q == CNT_LO_IDX) ? cur_cnt[7:0] :
                             (idx_q == CNT_HI_IDX) ? cur_cnt[15:8] :
                             cur_blk[8*idx_q[2:0] +: 8];
    wire        commit_ok  = (state_q == FMP_COMMIT) && allowed;
    wire        start      = (state_q == FMP_IDLE) && cmd_valid && blk_ok;

    fmp_guard u_guard (
        .blk      (blk_q),
        .prot_blk (prot_word),
        .old_data (cur_blk),
        .new_data (wbuf_q),
        .merged   (merged),
        .allowed  (allowed)
    );

    fmp_wcount u_wcount (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .inc_en (commit_ok),
        .inc_blk(blk_q),
        .rd_blk (blk_q),
        .rd_cnt (cur_cnt)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= FMP_IDLE;
            blk_q   <= '0;
            ext_q   <= 1'b0;
            idx_q   <= '0;
            wbuf_q  <= '0;
        end
        else
        begin
            unique case (state_q)
                FMP_IDLE:
                begin
                    idx_q <= '0;
                    if (start)
                    begin
                        blk_q   <= cmd_blk;
                        ext_q   <= cmd_ext;
                        state_q <= cmd_write ? FMP_WRITE : FMP_READ;
                    end
                end
                FMP_READ:
                begin
                    idx_q <= idx_q + 4'h1;
                    if (idx_q == last_idx)
                        state_q <= FMP_IDLE;
                end
                FMP_WRITE:
                    if (wr_byte_valid)
                    begin
                        wbuf_q[8*idx_q[2:0] +: 8] <= wr_byte;
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == LAST_DATA_IDX)
                            state_q <= FMP_COMMIT;
                    end
                FMP_COMMIT:
                    state_q <= FMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_BLOCKS; i++)
                mem_q[i] <= '0;
        end
        else if (commit_ok)
            mem_q[blk_q] <= merged;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy          <= 1'b0;
            rd_byte_valid <= 1'b0;
            rd_byte       <= '0;
            rd_last       <= 1'b0;
            wr_done       <= 1'b0;
            wr_accepted   <= 1'b0;
            cmd_error     <= 1'b0;
        end
        else
        begin
            busy          <= start || (state_q != FMP_IDLE && !(state_q == FMP_COMMIT)
                             && !(state_q == FMP_READ && idx_q == last_idx));
            rd_byte_valid <= (state_q == FMP_READ);
            rd_byte       <= (state_q == FMP_READ) ? out_byte : 8'h00;
            rd_last       <= (state_q == FMP_READ) && (idx_q == last_idx);
            wr_done       <= (state_q == FMP_COMMIT);
            wr_accepted   <= commit_ok;
            cmd_error     <= (state_q == FMP_IDLE) && cmd_valid && !blk_ok;
        end
    end

    AST_READ_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
        (start && !cmd_write && !cmd_ext) |-> ##8 (state_q == FMP_READ && idx_q == LAST_DATA_IDX))
        else $error("Plain read length wrong");
    AST_PROTECT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == FMP_COMMIT && !allowed) |=> (mem_q[$past(blk_q)] == $past(cur_blk)))
        else $error("Protected block changed");
    AST_SELF_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
        fmp_is_locked(mem_q[PROT_BLK][63:56]) |=> fmp_is_locked(mem_q[PROT_BLK][63:56]))
        else $error("Self lock changed");
    AST_EPROM_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
        (mem_q[PROT_BLK][23:16] == PROT_EPROM_EMU)
        |=> (mem_q[PROT_BLK][23:16] == PROT_EPROM_EMU))
        else $error("Emulation mode reverted");
    AST_WP_BITS: assert property (@(posedge mclk) disable iff (!rst_n)
        (mem_q[PROT_BLK][15:12] == PROT_WP_NIBBLE) |=> (mem_q[PROT_BLK][15:12] == PROT_WP_NIBBLE
        && (mem_q[PROT_BLK][11:8] & $past(mem_q[PROT_BLK][11:8])) == $past(mem_q[PROT_BLK][11:8])))
        else $error("Write-protect bits cleared");
    AST_APP_DATA_FIELD_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
        fmp_is_locked(mem_q[PROT_BLK][39:32]) |=> $stable(mem_q[PARAM_BLK][31:0]))
        else $error("Locked app data changed");
    AST_WR_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == FMP_COMMIT) |=> (wr_done && wr_accepted == $past(allowed)))
        else $error("Write completion misreported");
    AST_EXT_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
        (start && !cmd_write && cmd_ext) |-> ##10 (state_q == FMP_READ && idx_q == CNT_HI_IDX))
        else $error("Extended read length wrong");
endmodule // fmp_memory

// >>> rtl/fmp_pkg.sv
/*
 Package for the fob memory map and protection block: block numbers,
 byte positions inside the control blocks, protection codes and the
 write-cycle counter limit.
 Assumes a single clock domain; no other file defines these names.
*/
package fmp_pkg;
    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_BLOCKS     = 18;
    localparam int unsigned BYTES_PER_BLK  = 8;
    localparam int unsigned BLK_W          = 5;
    localparam int unsigned BYTE_IDX_W     = 4;
    localparam int unsigned CNT_W          = 16;

    localparam logic [4:0] USER_BLK_FIRST  = 5'h00;
    localparam logic [4:0] USER_BLK_LAST   = 5'h0f;
    localparam logic [4:0] PARAM_BLK       = 5'h10;
    localparam logic [4:0] PROT_BLK        = 5'h11;

    // Byte positions in the parameter block
    localparam int unsigned ADF_FIRST      = 0;
    localparam int unsigned ADF_LAST       = 3;
    localparam int unsigned FAMILY_ID_POS  = 4;
    localparam int unsigned USER1_POS      = 5;

    // Byte positions in the protection control block
    localparam int unsigned PAGE_PROT_POS  = 0;
    localparam int unsigned APP_DATA_FIELD_LOCK_POS   = 4;
    localparam int unsigned FID_LOCK_POS   = 5;
    localparam int unsigned FIRST_USER_BYTE_LOCK_POS    = 6;
    localparam int unsigned SELF_LOCK_POS  = 7;

    // Protection codes
    localparam logic [7:0] PROT_UNLOCKED   = 8'h00;
    localparam logic [7:0] PROT_EPROM_EMU  = 8'h0a;
    localparam logic [3:0] PROT_WP_NIBBLE  = 4'ha;
    localparam logic [7:0] LOCK_CODE       = 8'haa;

    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [15:0] CNT_ONE        = 16'h0001;
    localparam logic [3:0]  CNT_LO_IDX     = 4'h8;
    localparam logic [3:0]  CNT_HI_IDX     = 4'h9;
    localparam logic [3:0]  LAST_DATA_IDX  = 4'h7;

    typedef enum logic [1:0] {
        FMP_IDLE  = 2'b00,
        FMP_READ  = 2'b01,
        FMP_WRITE = 2'b10,
        FMP_COMMIT = 2'b11
    } fmp_state_e;

    // Lock byte holds the locking code
    function automatic logic fmp_is_locked(input logic [7:0] b);
        fmp_is_locked = (b == LOCK_CODE);
    endfunction
endpackage

// >>> rtl/fmp_wcount.sv
/*
 Bank of per-block saturating write-cycle counters.
 Assumes the caller pulses inc_en only for accepted writes.
*/
`timescale 1ns/1ps
module fmp_wcount
    import fmp_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      inc_en,
    input  wire logic [fmp_pkg::BLK_W-1:0] inc_blk,
    input  wire logic [fmp_pkg::BLK_W-1:0] rd_blk,
    output logic      [fmp_pkg::CNT_W-1:0] rd_cnt
);
    logic [CNT_W-1:0] cnt_q [NUM_BLOCKS];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_BLOCKS; i++)
                cnt_q[i] <= '0;
        end
        else if (inc_en && cnt_q[inc_blk] != CNT_MAX)
            cnt_q[inc_blk] <= cnt_q[inc_blk] + CNT_ONE;
    end

    assign rd_cnt = cnt_q[rd_blk];

    AST_SATURATE: assert property (@(posedge mclk) disable iff (!rst_n)
        (inc_en && cnt_q[inc_blk] == CNT_MAX) |=> (cnt_q[$past(inc_blk)] == CNT_MAX))
        else $error("Write counter wrapped");
    AST_INCREMENT: assert property (@(posedge mclk) disable iff (!rst_n)
        (inc_en && cnt_q[inc_blk] != CNT_MAX)
        |=> (cnt_q[$past(inc_blk)] == $past(cnt_q[inc_blk]) + CNT_ONE))
        else $error("Write counter did not step by one");
endmodule // fmp_wcount

// >>> rtl/fmp_guard.sv
/*
 Write-permission decode: folds the stored protection block and the
 stored target contents with the proposed block into the contents to
 commit, and flags whether any change is permitted at all.
 Assumes protection bytes come straight from storage.
*/
`timescale 1ns/1ps
module fmp_guard
    import fmp_pkg::*;
(
    input  wire logic [fmp_pkg::BLK_W-1:0] blk,
    input  wire logic [63:0]               prot_blk,
    input  wire logic [63:0]               old_data,
    input  wire logic [63:0]               new_data,
    output logic      [63:0]               merged,
    output logic                           allowed
);
    logic [1:0] page;
    logic [1:0] idx;
    logic [7:0] pbyte;
    logic       user_blk;
    logic       blk_wp;
    assign page     = blk[3:2];
    assign idx      = blk[1:0];
    assign user_blk = (blk <= USER_BLK_LAST);
    assign pbyte    = prot_blk[8*page +: 8];
    // Write protect: Ah upper nibble and the bit for this block set in its page byte
    assign blk_wp   = (pbyte[7:4] == PROT_WP_NIBBLE) && pbyte[idx];

    always_comb
    begin
        merged  = old_data;
        allowed = 1'b0;
        if (user_blk)
        begin
            if (blk_wp)
                allowed = 1'b0;
            else if (pbyte == PROT_EPROM_EMU)
            begin
                merged  = old_data | new_data;
                allowed = 1'b1;
            end
            else
            begin
                merged  = new_data;
                allowed = 1'b1;
            end
        end
        else if (blk == PARAM_BLK)
        begin
            merged = new_data;
            if (fmp_is_locked(prot_blk[8*APP_DATA_FIELD_LOCK_POS +: 8]))
                merged[31:0] = old_data[31:0];
            if (fmp_is_locked(prot_blk[8*FID_LOCK_POS +: 8]))
                merged[8*FAMILY_ID_POS +: 8] = old_data[8*FAMILY_ID_POS +: 8];
            if (fmp_is_locked(prot_blk[8*FIRST_USER_BYTE_LOCK_POS +: 8]))
                merged[8*USER1_POS +: 8] = old_data[8*USER1_POS +: 8];
            allowed = (merged != old_data) || (new_data == old_data);
        end
        else if (blk == PROT_BLK)
        begin
            merged = new_data;
            for (int p = 0; p < 4; p++)
            begin
                if (old_data[8*p+4 +: 4] == PROT_WP_NIBBLE)
                    merged[8*p +: 8] = {PROT_WP_NIBBLE,
                                        old_data[8*p +: 4] | new_data[8*p +: 4]};
                else if (old_data[8*p +: 8] == PROT_EPROM_EMU)
                    merged[8*p +: 8] = old_data[8*p +: 8];
            end
            for (int l = APP_DATA_FIELD_LOCK_POS; l <= SELF_LOCK_POS; l++)
                if (fmp_is_locked(old_data[8*l +: 8]))
                    merged[8*l +: 8] = old_data[8*l +: 8];
            allowed = (merged != old_data) || (new_data == old_data);
        end
    end
endmodule // fmp_guard

// >>> dv/fmp_reader.sv
/*
 Reader model: issues block reads and writes to the memory core.
 Assumes mclk runs and the core is out of reset before any task.
*/
`timescale 1ns/1ps
module fmp_reader
    import fmp_pkg::*;
(
    input  wire logic                      mclk,
    output logic                           cmd_valid,
    output logic                           cmd_write,
    output logic                           cmd_ext,
    output logic      [fmp_pkg::BLK_W-1:0] cmd_blk,
    output logic                           wr_byte_valid,
    output logic      [7:0]                wr_byte,
    input  wire logic                      busy,
    input  wire logic                      rd_byte_valid,
    input  wire logic [7:0]                rd_byte,
    input  wire logic                      rd_last,
    input  wire logic                      wr_done,
    input  wire logic                      wr_accepted,
    input  wire logic                      cmd_error
);
    // ------------------------------------------------------------
    // Command tasks
    // ------------------------------------------------------------
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_ext = 1'b0;
        cmd_blk = 5'h00;
        wr_byte_valid = 1'b0;
        wr_byte = 8'h00;
    end

    task automatic start(input logic [4:0] b, input logic w, input logic x);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_ext <= x;
        cmd_blk <= b;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        // Released lines show the inverse, not a stale copy
        cmd_blk <= ~b;
    endtask

    task automatic wr_blk(input logic [4:0] b, input logic [63:0] d,
                          output logic done, output logic acc);
        int i;
        start(b, 1'b1, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            if (i > 0) @(posedge mclk);
            wr_byte_valid <= 1'b1;
            wr_byte <= d[8*i+:8];
        end
        @(posedge mclk);
        wr_byte_valid <= 1'b0;
        wr_byte <= ~d[63:56];
        done = 1'b0;
        acc = 1'b0;
        for (i = 0; i < 20 && !done; i++)
        begin
            @(posedge mclk);
            #1;
            done = wr_done;
            acc = wr_accepted;
        end
    endtask

    task automatic rd_blk(input logic [4:0] b, input logic x,
                          output logic [79:0] d, output int n, output logic lst);
        int i;
        start(b, 1'b0, x);
        d = '0;
        n = 0;
        lst = 1'b0;
        for (i = 0; i < 30 && !lst && n < 10; i++)
        begin
            @(posedge mclk);
            #1;
            if (rd_byte_valid === 1'b1)
            begin
                d[8*n+:8] = rd_byte;
                n++;
                lst = rd_last;
            end
        end
    endtask

    task automatic bad_blk(output logic err, output logic bz);
        int i;
        start(5'h12, 1'b0, 1'b0);
        err = 1'b0;
        bz = 1'b0;
        for (i = 0; i < 4; i++)
        begin
            #1;
            err = err | cmd_error;
            bz = bz | busy;
            @(posedge mclk);
        end
    endtask
endmodule // fmp_reader

// >>> dv/fob_memory_map_protection_test.sv
/*
 Self-checking bench for the memory core: reference model of data,
 protection and counters, driven through the reader model.
 Assumes the core follows the hand-over timing; seed fixed at 56.
*/
`timescale 1ns/1ps
module fob_memory_map_protection_test;
    import fmp_pkg::*;
    logic mclk, rstn, cmd_valid, cmd_write, cmd_ext, wr_byte_valid;
    logic busy, rd_byte_valid, rd_last, wr_done, wr_accepted, cmd_error;
    logic [4:0] cmd_blk;
    logic [7:0] wr_byte, rd_byte;
    logic [63:0] mem_m [18];
    logic [15:0] cnt_m [18];
    int miscompares = 0;
    int comparisons = 0;
    int i, seed_tmp;
    int prot_blks[8] = '{5, 4, 0, 8, 9, 12, 16, 5};
    logic e1, e2;

    fmp_memory u_fmp_memory (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_ext(cmd_ext), .cmd_blk(cmd_blk),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .busy(busy),
        .rd_byte_valid(rd_byte_valid), .rd_byte(rd_byte), .rd_last(rd_last),
        .wr_done(wr_done), .wr_accepted(wr_accepted), .cmd_error(cmd_error));
    fmp_reader u_fmp_reader (.mclk(mclk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_ext(cmd_ext), .cmd_blk(cmd_blk),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .busy(busy),
        .rd_byte_valid(rd_byte_valid), .rd_byte(rd_byte), .rd_last(rd_last),
        .wr_done(wr_done), .wr_accepted(wr_accepted), .cmd_error(cmd_error));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Checking and expectation
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_val(nm, {63'h0, e}, {63'h0, g});
    endtask

    function automatic logic [63:0] exp_merge(input int b, input logic [63:0] o,
                                              input logic [63:0] n);
        logic [63:0] m;
        logic [63:0] p;
        logic [7:0] pb;
        int k;
        p = mem_m[17];
        m = n;
        if (b < 16)
        begin
            pb = p[8*(b/4)+:8];
            if (pb === PROT_EPROM_EMU) m = o | n;
            else if (pb[7:4] === PROT_WP_NIBBLE && pb[b%4]) m = o;
        end
        else if (b == 16)
        begin
            if (p[39:32] === LOCK_CODE) m[31:0] = o[31:0];
            if (p[47:40] === LOCK_CODE) m[39:32] = o[39:32];
            if (p[55:48] === LOCK_CODE) m[47:40] = o[47:40];
        end
        else
        begin
            for (k = 0; k < 4; k++)
            begin
                pb = o[8*k+:8];
                if (pb === PROT_EPROM_EMU) m[8*k+:8] = pb;
                else if (pb[7:4] === PROT_WP_NIBBLE)
                    m[8*k+:8] = {pb[7:4], pb[3:0] | n[8*k+:4]};
            end
            for (k = 4; k < 8; k++)
                if (o[8*k+:8] === LOCK_CODE) m[8*k+:8] = o[8*k+:8];
        end
        return m;
    endfunction

    task automatic rd(input int b);
        logic [79:0] d;
        int n;
        logic lst;
        u_fmp_reader.rd_blk(5'(b), 1'b1, d, n, lst);
        chk_val("ext_count", 64'd10, 64'(n));
        chk_flag("rd_last", 1'b1, lst);
        chk_val("ext_data", mem_m[b], d[63:0]);
        chk_val("counter", {48'h0, cnt_m[b]}, {48'h0, d[79:64]});
        u_fmp_reader.rd_blk(5'(b), 1'b0, d, n, lst);
        chk_val("plain_count", 64'd8, 64'(n));
        chk_val("plain_data", mem_m[b], d[63:0]);
    endtask

    task automatic wr(input int b, input logic [63:0] d);
        logic [63:0] e;
        logic done, acc, ea;
        e = exp_merge(b, mem_m[b], d);
        // User block: refused only by its write-protect bit, emulation still accepts
        if (b < 16)
            ea = !(mem_m[17][8*(b/4)+4+:4] === PROT_WP_NIBBLE && mem_m[17][8*(b/4)+b%4]);
        else
            ea = (e !== mem_m[b]) || (d === mem_m[b]);
        u_fmp_reader.wr_blk(5'(b), d, done, acc);
        chk_flag("wr_done", 1'b1, done);
        chk_flag("wr_accepted", ea, acc);
        if (ea)
        begin
            mem_m[b] = e;
            if (cnt_m[b] !== CNT_MAX) cnt_m[b] = cnt_m[b] + 16'h0001;
        end
        rd(b);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        seed_tmp = $urandom(56);
        for (i = 0; i < 18; i++)
        begin
            mem_m[i] = 64'h0;
            cnt_m[i] = 16'h0;
        end
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk_flag("idle_out", 1'b0, busy | rd_byte_valid | rd_last | wr_done | cmd_error);
        for (i = 0; i < 18; i++) rd(i);
        $display("test reset_map done");
        for (i = 0; i < 6; i++) wr($urandom % 16, {$urandom, $urandom});
        wr(16, {$urandom, $urandom});
        wr(3, 64'h0123_4567_89ab_cdef);
        wr(3, 64'h0123_4567_89ab_cdef);
        $display("test plain_writes done");
        wr(17, 64'haa00_55aa_000a_a200);
        foreach (prot_blks[j])
            wr(prot_blks[j], {$urandom, $urandom});
        wr(17, {$urandom, $urandom});
        wr(17, ~mem_m[17]);
        wr(5, {$urandom, $urandom});
        wr(16, ~mem_m[16]);
        $display("test protection done");
        u_fmp_reader.bad_blk(e1, e2);
        chk_flag("cmd_error", 1'b1, e1);
        chk_flag("busy", 1'b0, e2);
        $display("test bad_block done");
        end_sim();
    end

    initial
    begin
        #3_000_000;
        miscompares++;
        end_sim();
    end
endmodule // fob_memory_map_protection_test
